// file: core/sss_fifo.sv
`timescale 1ns/10ps
module sss_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule : sss_fifo

// file: core/sss_pkg.sv
package sss_pkg;
  // ---------------------------------------------------------------
  // channel numbers and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_DIGITAL   = 8'hC1;  // 193
  localparam logic [7:0] CH_FIRST_TIMER    = 8'hC8;  // 200
  localparam logic [7:0] CH_SECOND_TIMER    = 8'hC9;  // 201
  localparam logic [7:0] CH_FIRST_COUNTER  = 8'hD2;  // 210
  localparam logic [7:0] CH_SECOND_COUNTER  = 8'hD3;  // 211
  localparam logic [7:0] CH_CAPTURE   = 8'hE0;  // 224
  localparam int unsigned CLK_HZ      = 50000000;
  localparam int unsigned RATE_R0     = 2500;
  localparam int unsigned RATE_R1     = 10000;
  localparam int unsigned RATE_R2     = 20000;
  localparam int unsigned RATE_R3     = 50000;
  // interchannel delay in ns, derived cycle counts (longest time, round down)
  localparam int unsigned ICD_R0_NS   = 320000;
  localparam int unsigned ICD_R1_NS   = 82000;
  localparam int unsigned ICD_R2_NS   = 42000;
  localparam int unsigned ICD_R3_NS   = 12500;
  localparam int unsigned NS_PER_CLK  = 1000000000 / CLK_HZ;
  localparam int unsigned ICD_R0_CYC  = ICD_R0_NS / NS_PER_CLK;
  localparam int unsigned ICD_R1_CYC  = ICD_R1_NS / NS_PER_CLK;
  localparam int unsigned ICD_R2_CYC  = ICD_R2_NS / NS_PER_CLK;
  localparam int unsigned ICD_R3_CYC  = ICD_R3_NS / NS_PER_CLK;
  localparam int unsigned SETTLE_CYC  = 64;
  localparam int unsigned FAST_CYC    = 4;
  localparam int unsigned SLOW_CYC    = 16;
  localparam int unsigned TIMER_MODE_SYS_HI = 11;
  localparam int unsigned ADC_BITS    = 12;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned PKT_SAMPLES = 4;
  localparam int unsigned LIST_MAX    = 16;

  typedef struct packed {
    logic [15:0] word;
    logic [7:0]  chan;
  } sss_sample_s;

  typedef struct packed {
    logic [15:0] seq;
    logic [15:0] dropped;
    logic [15:0] checksum;
  } sss_pkt_info_s;
endpackage : sss_pkg

// file: core/sss_sequencer.sv
`timescale 1ns/10ps
module sss_sequencer #(
  parameter int unsigned LIST_LEN_MAX = sss_pkg::LIST_MAX,
  parameter int unsigned FIFO_WORDS   = sss_pkg::FIFO_DEPTH,
  parameter int unsigned PKT_LEN      = sss_pkg::PKT_SAMPLES
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // command / response
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_stream_start,
  input  wire logic                 cmd_stream_stop,
  output logic                      rsp_valid,
  output logic [15:0]               rsp_adc_word,
  output logic [15:0]               rsp_digital_word,
  // stream configuration
  input  wire logic [1:0]           resolution_index,
  input  wire logic [31:0]          scan_period_cycles,
  input  wire logic [4:0]           list_len,
  input  wire logic [7:0]           list_chan [LIST_LEN_MAX],
  input  wire logic                 fast_conversion_option,
  input  wire logic                 extended_settling_option,
  input  wire logic [3:0]           first_timer_mode,
  input  wire logic [3:0]           second_timer_mode,
  // live inputs
  input  wire logic [7:0]           flexible_io_lines,
  input  wire logic [7:0]           extended_io_lines,
  input  wire logic [31:0]          first_timer,
  input  wire logic [31:0]          second_timer,
  input  wire logic [31:0]          first_counter,
  input  wire logic [31:0]          second_counter,
  input  wire logic [11:0]          adc_result,
  // stream output
  output logic                      smp_valid,
  input  wire logic                 smp_ready,
  output sss_pkg::sss_sample_s      smp_data,
  output logic                      pkt_end,
  output sss_pkg::sss_pkt_info_s    pkt_info,
  // status
  output logic                      streaming,
  output logic                      config_error,
  output logic                      overflow_active
);
  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (srst);
  initial if (LIST_LEN_MAX > 31 || PKT_LEN < 1 || FIFO_WORDS < 2) $error("bad parameters");

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] icd_cycles(input logic [1:0] r);
    unique case (r)
      2'h0: icd_cycles = 32'(sss_pkg::ICD_R0_CYC);
      2'h1: icd_cycles = 32'(sss_pkg::ICD_R1_CYC);
      2'h2: icd_cycles = 32'(sss_pkg::ICD_R2_CYC);
      2'h3: icd_cycles = 32'(sss_pkg::ICD_R3_CYC);
    endcase
  endfunction : icd_cycles

  function automatic logic [31:0] max_rate(input logic [1:0] r);
    unique case (r)
      2'h0: max_rate = 32'(sss_pkg::RATE_R0);
      2'h1: max_rate = 32'(sss_pkg::RATE_R1);
      2'h2: max_rate = 32'(sss_pkg::RATE_R2);
      2'h3: max_rate = 32'(sss_pkg::RATE_R3);
    endcase
  endfunction : max_rate

  function automatic logic is_lower_word(input logic [7:0] c);
    is_lower_word = (c == sss_pkg::CH_FIRST_TIMER) || (c == sss_pkg::CH_SECOND_TIMER) ||
                    (c == sss_pkg::CH_FIRST_COUNTER) || (c == sss_pkg::CH_SECOND_COUNTER);
  endfunction : is_lower_word

  // ---------------------------------------------------------------
  // single command/response exchange
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rsp_valid        <= 1'b0;
      rsp_adc_word     <= '0;
      rsp_digital_word <= '0;
    end else begin
      // only a command ever yields a response, one per cycle of cmd_valid, none while streaming
      rsp_valid <= cmd_valid && !streaming;
      if (cmd_valid && !streaming) begin
        rsp_adc_word     <= {4'h0, adc_result};
        rsp_digital_word <= {extended_io_lines, flexible_io_lines};
      end
    end
  end

  // ---------------------------------------------------------------
  // scan timing
  // ---------------------------------------------------------------
  // scan period must not beat max rate / list length; 50 MHz / rate * len
  logic [31:0] min_period;
  logic        start_ok;
  logic [31:0] scan_cnt_q;
  logic [31:0] gap_cnt_q;
  logic [4:0]  idx_q;
  logic        in_scan_q;
  logic        sample_now;
  logic [31:0] conv_cycles;
  logic        sys_hi_used;

  assign min_period = 32'(sss_pkg::CLK_HZ) / max_rate(resolution_index) * 32'(list_len);
  // extended settling and fast conversion stretch or shrink the first slot of each scan
  assign conv_cycles = (fast_conversion_option ? 32'(sss_pkg::FAST_CYC)
                        : 32'(sss_pkg::SLOW_CYC)) +
                       (extended_settling_option ? 32'(sss_pkg::SETTLE_CYC) : 32'h0);
  always_comb begin
    sys_hi_used = 1'b0;
    for (int i = 0; i < LIST_LEN_MAX; i++) begin
      if (5'(i) < list_len) begin
        if ((list_chan[i] == sss_pkg::CH_FIRST_TIMER &&
             first_timer_mode == 4'(sss_pkg::TIMER_MODE_SYS_HI)) ||
            (list_chan[i] == sss_pkg::CH_SECOND_TIMER &&
             second_timer_mode == 4'(sss_pkg::TIMER_MODE_SYS_HI))) begin
          sys_hi_used = 1'b1;
        end
      end
    end
  end
  assign start_ok = (list_len != 5'h0) && (5'(LIST_LEN_MAX) >= list_len) &&
                    (scan_period_cycles >= min_period) && !sys_hi_used;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      streaming    <= 1'b0;
      config_error <= 1'b0;
    end else if (cmd_stream_start && !streaming) begin
      streaming    <= start_ok;
      config_error <= !start_ok;
    end else if (cmd_stream_stop) begin
      streaming    <= 1'b0;
    end
  end

  assign sample_now = streaming && in_scan_q && gap_cnt_q == 32'h0;

  always_ff @(posedge core_clk) begin
    if (srst || !streaming) begin
      scan_cnt_q <= '0;
      gap_cnt_q  <= '0;
      idx_q      <= '0;
      in_scan_q  <= 1'b0;
    end else begin
      // scan starts are spaced by the period, not by scan length
      scan_cnt_q <= (scan_cnt_q + 32'h1 >= scan_period_cycles) ? 32'h0 : scan_cnt_q + 32'h1;
      if (scan_cnt_q == 32'h0) begin
        in_scan_q <= 1'b1;
        idx_q     <= '0;
        gap_cnt_q <= conv_cycles;
      end else if (gap_cnt_q != 32'h0) begin
        gap_cnt_q <= gap_cnt_q - 32'h1;
      end else if (in_scan_q) begin
        // special channels use the same slot as analog ones
        if (idx_q + 5'h1 >= list_len) begin
          in_scan_q <= 1'b0;
        end else begin
          idx_q     <= idx_q + 5'h1;
          gap_cnt_q <= icd_cycles(resolution_index) - 32'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // channel value and upper word capture
  // ---------------------------------------------------------------
  logic [7:0]  cur_chan;
  logic [15:0] cur_word;
  logic [15:0] upper_word_capture_q;
  assign cur_chan = list_chan[idx_q[$clog2(LIST_LEN_MAX)-1:0]];

  always_comb begin
    unique case (cur_chan)
      // unconfigured lines still read, value just meaningless
      sss_pkg::CH_DIGITAL:  cur_word = {extended_io_lines, flexible_io_lines};
      sss_pkg::CH_FIRST_TIMER:   cur_word = first_timer[15:0];
      sss_pkg::CH_SECOND_TIMER:   cur_word = second_timer[15:0];
      sss_pkg::CH_FIRST_COUNTER: cur_word = first_counter[15:0];
      sss_pkg::CH_SECOND_COUNTER: cur_word = second_counter[15:0];
      sss_pkg::CH_CAPTURE:  cur_word = upper_word_capture_q;
      default:              cur_word = {4'h0, adc_result};
    endcase
  end

  // upper and lower words come from one snapshot; a period-mode timer may
  // still roll between hardware updates and read low by 65536
  always_ff @(posedge core_clk) begin
    if (srst) begin
      upper_word_capture_q <= '0;
    end else if (sample_now && is_lower_word(cur_chan)) begin
      unique case (cur_chan)
        sss_pkg::CH_FIRST_TIMER:   upper_word_capture_q <= first_timer[31:16];
        sss_pkg::CH_SECOND_TIMER:   upper_word_capture_q <= second_timer[31:16];
        sss_pkg::CH_FIRST_COUNTER: upper_word_capture_q <= first_counter[31:16];
        default:              upper_word_capture_q <= second_counter[31:16];
      endcase
    end // else holds until overwritten
  end

  // ---------------------------------------------------------------
  // buffering with auto-recovery
  // ---------------------------------------------------------------
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  sss_pkg::sss_sample_s  fifo_out_data;
  logic                  fifo_push;
  logic [15:0]           pkt_cnt_q;
  logic [15:0]           dropped_q;
  logic [15:0]           seq_q;
  logic [15:0]           sum_q;
  logic [15:0]           drop_smp_q;

  assign fifo_push = sample_now && !overflow_active;

  sss_fifo #(
    .WIDTH ($bits(sss_pkg::sss_sample_s)),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({cur_word, cur_chan}),
    .out_valid (fifo_out_valid),
    .out_ready (smp_ready || !smp_valid),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      overflow_active <= 1'b0;
      drop_smp_q      <= '0;
      dropped_q       <= '0;
    end else begin
      if (sample_now && !overflow_active && !fifo_in_ready) begin
        overflow_active <= 1'b1;
      end else if (overflow_active && !fifo_out_valid) begin
        overflow_active <= 1'b0;
      end
      if (sample_now && (overflow_active || !fifo_in_ready)) begin
        // a packet's worth of dropped samples counts as one packet
        if (drop_smp_q + 16'h1 >= 16'(PKT_LEN)) begin
          drop_smp_q <= '0;
          dropped_q  <= dropped_q + 16'h1;
        end else begin
          drop_smp_q <= drop_smp_q + 16'h1;
        end
      end
    end
  end

  // output register with packet framing
  always_ff @(posedge core_clk) begin
    if (srst) begin
      smp_valid <= 1'b0;
      smp_data  <= '0;
      pkt_end   <= 1'b0;
      pkt_info  <= '0;
      pkt_cnt_q <= '0;
      seq_q     <= '0;
      sum_q     <= '0;
    end else if (smp_ready || !smp_valid) begin
      smp_valid <= fifo_out_valid;
      smp_data  <= fifo_out_data;
      pkt_end   <= 1'b0;
      if (fifo_out_valid) begin
        if (pkt_cnt_q + 16'h1 >= 16'(PKT_LEN)) begin
          pkt_cnt_q <= '0;
          pkt_end   <= 1'b1;
          sum_q     <= '0;
          seq_q     <= seq_q + 16'h1;
          pkt_info  <= '{seq: seq_q, dropped: dropped_q,
                         checksum: sum_q + fifo_out_data.word};
        end else begin
          pkt_cnt_q <= pkt_cnt_q + 16'h1;
          sum_q     <= sum_q + fifo_out_data.word;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_one_response: assert property (rsp_valid |-> $past(cmd_valid) && !$past(streaming))
    else $error("response without command");
  a_capture_latch: assert property (sample_now && cur_chan == sss_pkg::CH_FIRST_TIMER |=>
    upper_word_capture_q == $past(first_timer[31:16]))
    else $error("capture missed timer upper word");
  a_capture_hold: assert property (!(sample_now && is_lower_word(cur_chan)) |=>
    $stable(upper_word_capture_q))
    else $error("capture changed without lower word");
  a_drop_while_ovf: assert property (overflow_active |=> $stable(u_fifo.wr_q))
    else $error("stored during overflow");
  a_ovf_exit: assert property ($fell(overflow_active) |-> !$past(fifo_out_valid))
    else $error("recovered before drain");
  a_digital_word: assert property (sample_now && cur_chan == sss_pkg::CH_DIGITAL |->
    cur_word == {extended_io_lines, flexible_io_lines})
    else $error("digital word order wrong");
  a_rate_limit: assert property ($rose(streaming) |-> scan_period_cycles >= min_period)
    else $error("stream started above max rate");
  a_no_sys_hi: assert property ($rose(streaming) |-> !sys_hi_used)
    else $error("system timer upper mode streamed");
  a_icd_gap: assert property (sample_now && in_scan_q && idx_q + 5'h1 < list_len &&
    resolution_index == 2'h3 && scan_cnt_q != 32'h0 |=> !sample_now [*8])
    else $error("channels closer than delay");
  c_stream: cover property ($rose(streaming));
  c_overflow: cover property ($fell(overflow_active));
  c_packet: cover property (pkt_end);
  c_capture: cover property (sample_now && cur_chan == sss_pkg::CH_CAPTURE);
endmodule : sss_sequencer

// file: test/scan_stream_sequencer_tb_top.sv
`timescale 1ns/10ps
`define chk(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module scan_stream_sequencer_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        core_clk, srst, cmd_valid, cmd_stream_start, cmd_stream_stop;
  logic        rsp_valid, fast_conversion_option, extended_settling_option;
  logic        smp_valid, smp_ready, pkt_end, streaming, config_error;
  logic        overflow_active, stall;
  logic [15:0] rsp_adc_word, rsp_digital_word;
  logic [1:0]  resolution_index;
  logic [31:0] scan_period_cycles, first_timer, second_timer, first_counter, second_counter;
  logic [4:0]  list_len;
  logic [7:0]  list_chan [16];
  logic [3:0]  first_timer_mode, second_timer_mode;
  logic [7:0]  flexible_io_lines, extended_io_lines;
  logic [11:0] adc_result;
  int          mismatches, tests_run;
  sss_pkg::sss_sample_s   smp_data;
  sss_pkg::sss_pkt_info_s pkt_info;

  sss_sequencer i_sss_sequencer (
    .core_clk(core_clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_stream_start(cmd_stream_start), .cmd_stream_stop(cmd_stream_stop),
    .rsp_valid(rsp_valid), .rsp_adc_word(rsp_adc_word), .rsp_digital_word(rsp_digital_word),
    .resolution_index(resolution_index), .scan_period_cycles(scan_period_cycles),
    .list_len(list_len), .list_chan(list_chan),
    .fast_conversion_option(fast_conversion_option),
    .extended_settling_option(extended_settling_option),
    .first_timer_mode(first_timer_mode), .second_timer_mode(second_timer_mode),
    .flexible_io_lines(flexible_io_lines), .extended_io_lines(extended_io_lines),
    .first_timer(first_timer), .second_timer(second_timer),
    .first_counter(first_counter), .second_counter(second_counter),
    .adc_result(adc_result), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_data(smp_data), .pkt_end(pkt_end), .pkt_info(pkt_info), .streaming(streaming),
    .config_error(config_error), .overflow_active(overflow_active));

  sss_host_model i_host (
    .core_clk(core_clk), .srst(srst), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_data(smp_data), .pkt_end(pkt_end), .pkt_info(pkt_info), .stall(stall));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic set_list(input logic [7:0] a, b, c, d, input int len);
    foreach (list_chan[i]) list_chan[i] = 8'h00;
    list_chan[0] = a;
    list_chan[1] = b;
    list_chan[2] = c;
    list_chan[3] = d;
    list_len = 5'(len);
  endtask : set_list

  task automatic start_stream(input logic [1:0] res, input logic [31:0] per);
    resolution_index = res;
    scan_period_cycles = per;
    cmd_stream_start = 1'b1;
    step();
    cmd_stream_start = 1'b0;
    step();
  endtask : start_stream

  // stop, let the fifo run dry, then forget what arrived
  task automatic stop_drain();
    cmd_stream_stop = 1'b1;
    step();
    cmd_stream_stop = 1'b0;
    stall = 1'b0;
    repeat (60) step();
    `chk(streaming, 1'b0)
    i_host.words.delete();
    i_host.chans.delete();
    i_host.when_q.delete();
  endtask : stop_drain

  task automatic wait_rx(input int n);
    for (int k = 0; k < 40000 && i_host.words.size() < n; k++) step();
    `chk(i_host.words.size() >= n, 1'b1)
  endtask : wait_rx

  task automatic check_pkt(input logic [15:0] exp [4]);
    logic [15:0] sum;
    sum = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      `chk(i_host.words[i], exp[i])
      `chk(i_host.chans[i], list_chan[i])
      sum = sum + exp[i];
    end
    `chk(i_host.last_info.checksum, sum)
    `chk(i_host.when_q[1] - i_host.when_q[0], 625)
  endtask : check_pkt

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_command();
    adc_result = 12'hABC;
    flexible_io_lines = 8'h5A;
    extended_io_lines = 8'hC3;
    cmd_valid = 1'b1; // host opens the exchange
    step();
    `chk(rsp_valid, 1'b1)
    `chk(rsp_adc_word, 16'h0ABC)
    `chk(rsp_digital_word, 16'hC35A)
    adc_result = 12'h123;
    step();
    cmd_valid = 1'b0;
    `chk(rsp_adc_word, 16'h0123)
    step();
    `chk(rsp_valid, 1'b0)
    $display("t_command done");
  endtask : t_command

  task automatic t_rates();
    int rate [4] = '{2500, 10000, 20000, 50000};
    int icd [4] = '{16000, 4100, 2100, 625};
    int per;
    set_list(8'h00, 8'h01, 8'h00, 8'h00, 2);
    for (int r = 0; r < 4; r++) begin
      per = 50000000 / rate[r] * 2;
      start_stream(2'(r), 32'(per - 1));
      `chk(config_error, 1'b1)
      `chk(streaming, 1'b0)
      start_stream(2'(r), 32'(per));
      `chk(config_error, 1'b0)
      `chk(streaming, 1'b1)
      wait_rx(2);
      `chk(i_host.when_q[1] - i_host.when_q[0], icd[r])
      stop_drain();
    end
    for (int t = 0; t < 2; t++) begin
      set_list(t == 0 ? sss_pkg::CH_FIRST_TIMER : sss_pkg::CH_SECOND_TIMER, 8'h00, 8'h00, 8'h00, 1);
      first_timer_mode = (t == 0) ? 4'hB : 4'h2;
      second_timer_mode = (t == 0) ? 4'h2 : 4'hB;
      start_stream(2'd3, 32'd1000);
      `chk(config_error, 1'b1)
      first_timer_mode = 4'h2; // timers set up before the stream starts
      second_timer_mode = 4'h2;
      start_stream(2'd3, 32'd1000);
      `chk(streaming, 1'b1)
      stop_drain();
    end
    $display("t_rates done");
  endtask : t_rates

  task automatic t_special();
    logic [15:0] seq0;
    first_timer = 32'h1234_5678;
    second_timer = 32'h9ABC_DEF0;
    first_counter = 32'h0F1E_2D3C;
    second_counter = 32'h4B5A_6978;
    flexible_io_lines = 8'hA5;
    extended_io_lines = 8'h3C;
    // capture channel follows its lower word
    set_list(sss_pkg::CH_DIGITAL, sss_pkg::CH_FIRST_TIMER, sss_pkg::CH_CAPTURE,
             sss_pkg::CH_SECOND_COUNTER, 4);
    start_stream(2'd3, 32'd4000);
    wait_rx(4);
    check_pkt('{16'h3CA5, 16'h5678, 16'h1234, 16'h6978});
    seq0 = i_host.last_info.seq;
    stop_drain();
    // second capture read repeats the held upper word
    set_list(sss_pkg::CH_SECOND_TIMER, sss_pkg::CH_FIRST_COUNTER, sss_pkg::CH_CAPTURE,
             sss_pkg::CH_CAPTURE, 4);
    start_stream(2'd3, 32'd4000);
    wait_rx(4);
    check_pkt('{16'hDEF0, 16'h2D3C, 16'h0F1E, 16'h0F1E});
    `chk(i_host.last_info.seq, seq0 + 16'h1)
    stop_drain();
    $display("t_special done");
  endtask : t_special

  task automatic t_latency();
    int lat [3];
    set_list(8'h00, 8'h00, 8'h00, 8'h00, 1);
    for (int m = 0; m < 3; m++) begin
      fast_conversion_option = (m == 1);
      extended_settling_option = (m == 2);
      start_stream(2'd3, 32'd1000);
      lat[m] = i_host.cyc;
      wait_rx(3);
      lat[m] = i_host.when_q[0] - lat[m];
      if (m == 0) `chk(i_host.when_q[2] - i_host.when_q[1], 1000)
      stop_drain();
    end
    fast_conversion_option = 1'b0;
    extended_settling_option = 1'b0;
    `chk(lat[0] - lat[1], 12)
    `chk(lat[2] - lat[0], 64)
    $display("t_latency done");
  endtask : t_latency

  task automatic t_overflow();
    int k;
    set_list(8'h00, 8'h00, 8'h00, 8'h00, 1);
    stall = 1'b1;
    start_stream(2'd3, 32'd1000);
    for (k = 0; k < 30000 && overflow_active !== 1'b1; k++) step();
    `chk(overflow_active, 1'b1)
    `chk(i_host.words.size(), 0)
    cmd_valid = 1'b1;
    step();
    cmd_valid = 1'b0;
    step();
    `chk(rsp_valid, 1'b0)
    repeat (8000) step();
    stall = 1'b0;
    for (k = 0; k < 200 && overflow_active !== 1'b0; k++) step();
    `chk(overflow_active, 1'b0)
    repeat (4) step();
    `chk(i_host.words.size() >= 16, 1'b1)
    wait_rx(i_host.words.size() + 8);
    `chk(i_host.last_info.dropped != 16'h0000, 1'b1)
    stop_drain();
    $display("t_overflow done");
  endtask : t_overflow

  // ---------------------------------------------------------------
  // clock, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    mismatches = 0;
    tests_run = 0;
    srst = 1'b1;
    {cmd_valid, cmd_stream_start, cmd_stream_stop, stall} = 4'h0;
    {fast_conversion_option, extended_settling_option} = 2'h0;
    resolution_index = 2'h3;
    scan_period_cycles = 32'h0000_03E8;
    first_timer_mode = 4'h2;
    second_timer_mode = 4'h2;
    {first_timer, second_timer, first_counter, second_counter} = 128'h0;
    {flexible_io_lines, extended_io_lines, adc_result} = 28'h0;
    set_list(8'h00, 8'h00, 8'h00, 8'h00, 1);
    repeat (2) step();
    srst = 1'b0;
    t_command();
    t_rates();
    t_special();
    t_latency();
    t_overflow();
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    finish_test();
  end
endmodule : scan_stream_sequencer_tb_top

// file: test/sss_host_model.sv
`timescale 1ns/10ps
module sss_host_model (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  // stream from the device
  input  wire logic                   smp_valid,
  output logic                        smp_ready,
  input  wire sss_pkg::sss_sample_s   smp_data,
  input  wire logic                   pkt_end,
  input  wire sss_pkg::sss_pkt_info_s pkt_info,
  // bench control
  input  wire logic                   stall
);
  // ---------------------------------------------------------------
  // received samples, with the cycle of each handshake
  // ---------------------------------------------------------------
  logic [15:0]            words [$];
  logic [7:0]             chans [$];
  int                     when_q [$];
  int                     cyc = 0;
  sss_pkg::sss_pkt_info_s last_info;

  // a stalled host lets the device fifo fill up, as a slow link would
  assign smp_ready = !stall;

  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (!srst && smp_valid === 1'b1 && smp_ready) begin
      words.push_back(smp_data.word);
      chans.push_back(smp_data.chan);
      when_q.push_back(cyc);
      if (pkt_end === 1'b1) begin
        last_info = pkt_info;
      end
    end
  end
endmodule : sss_host_model
